// ===== src/mpc_pkg.sv
package mpc_pkg;

	// ----------------------------------------------------------------
	// SMBus slave constants
	// ----------------------------------------------------------------
	localparam logic [6:0] SMB_ADDR = 7'h2E;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	// One-hot SMBus slave states
	typedef enum logic [3:0] {
		SS_IDLE = 4'h1,
		SS_ADDR = 4'h2,
		SS_WDAT = 4'h4,
		SS_RDAT = 4'h8
	} mpc_smb_state_t;

	// ----------------------------------------------------------------
	// Register map reached through the SMBus pointer
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h41;
	localparam logic [7:0] OFS_REMOTE = 8'h4A;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] FAN_FULL = 8'hFF;
	localparam logic [7:0] FAN_STOP = 8'h00;

	// Field positions
	localparam int CFG_INT_EN = 1;
	localparam int CFG_GEN_POL = 2;
	localparam int CFG_FAN_OFF = 3;
	localparam int ST_TRIP = 0;
	localparam int ST_GEN_IN = 4;
	localparam int ST_ALERT = 5;
	localparam int RF_RESET = 0;
	localparam int RF_PDOWN = 1;

	// ----------------------------------------------------------------
	// Pin synchroniser lanes and their idle levels
	// ----------------------------------------------------------------
	localparam int PIN_N = 6;
	localparam int P_SCL = 0;
	localparam int P_SDA = 1;
	localparam int P_AUX = 2;
	localparam int P_PWR = 3;
	localparam int P_GEN = 4;
	localparam int P_TST = 5;
	localparam logic [5:0] PIN_RST = 6'h0F;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int RRST_PULSE_NS = 10000;
	localparam logic [7:0] RRST_CYC =
		8'((RRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CNT8_ONE = 8'h01;

endpackage : mpc_pkg

// ===== src/mpc_smb_slave.sv
`timescale 1ns/1ps
module mpc_smb_slave (
	input wire logic sys_clk,
	input wire logic rst_any,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] rd_data,
	output logic sda_oe,
	output logic [7:0] ptr,
	output logic [7:0] wr_data,
	output logic wr_stb
);

	// ----------------------------------------------------------------
	// Bus condition detection
	// ----------------------------------------------------------------
	logic scl_q;
	logic sda_q;
	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;
	mpc_pkg::mpc_smb_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic first_reg;

	// Previous line levels
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Start, stop and clock edges
	assign start_c = scl & scl_q & sda_q & ~sda;
	assign stop_c = scl & scl_q & ~sda_q & sda;
	assign rise_c = scl & ~scl_q;
	assign fall_c = ~scl & scl_q;

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	// address match, pointer then data
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			state_reg <= mpc_pkg::SS_IDLE;
			cnt_reg <= mpc_pkg::CNT_ZERO;
			sh_reg <= mpc_pkg::BYTE_ZERO;
			tx_reg <= mpc_pkg::BYTE_ZERO;
			first_reg <= 1'b0;
			sda_oe <= 1'b0;
			ptr <= mpc_pkg::BYTE_ZERO;
			wr_data <= mpc_pkg::BYTE_ZERO;
			wr_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (start_c) begin
				state_reg <= mpc_pkg::SS_ADDR;
				cnt_reg <= mpc_pkg::CNT_ZERO;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				state_reg <= mpc_pkg::SS_IDLE;
				sda_oe <= 1'b0;
			end else if (state_reg != mpc_pkg::SS_IDLE) begin
				if (rise_c) begin
					if (cnt_reg == mpc_pkg::ACK_SLOT) begin
						cnt_reg <= mpc_pkg::CNT_ZERO;
						if (state_reg == mpc_pkg::SS_RDAT && sda) begin
							state_reg <= mpc_pkg::SS_IDLE;
						end
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
						sh_reg <= {sh_reg[6:0], sda};
					end
				end else if (fall_c) begin
					if (cnt_reg == mpc_pkg::ACK_SLOT) begin
						case (state_reg)
							mpc_pkg::SS_ADDR: begin
								if (sh_reg[7:1] == mpc_pkg::SMB_ADDR) begin
									sda_oe <= 1'b1;
									first_reg <= 1'b1;
									state_reg <= sh_reg[0] ? mpc_pkg::SS_RDAT : mpc_pkg::SS_WDAT;
								end else begin
									state_reg <= mpc_pkg::SS_IDLE;
								end
							end
							mpc_pkg::SS_WDAT: begin
								sda_oe <= 1'b1;
								first_reg <= 1'b0;
								if (first_reg) begin
									ptr <= sh_reg;
								end else begin
									wr_data <= sh_reg;
									wr_stb <= 1'b1;
								end
							end
							default: begin
								sda_oe <= 1'b0;
							end
						endcase
					end else if (state_reg == mpc_pkg::SS_RDAT) begin
						if (cnt_reg == mpc_pkg::CNT_ZERO) begin
							sda_oe <= ~rd_data[7];
							tx_reg <= {rd_data[6:0], 1'b0};
						end else begin
							sda_oe <= ~tx_reg[7];
							tx_reg <= {tx_reg[6:0], 1'b0};
						end
					end else begin
						sda_oe <= 1'b0;
					end
				end
			end
		end
	end

endmodule : mpc_smb_slave

// ===== src/mpc_top.sv
`timescale 1ns/1ps
// Operation
// - Fan off request drives pin low
// - Active input by polarity sets status bit4
// - Aux reset low resets all logic except the pin synchronisers
// - Power lost stops fan, clears power-down
// - Reset message pulses remote reset low
// - Test pin high selects NAND tree
// - Over-temp asserts alert, fan full speed
// - Test mode routes NAND result out
// - Secondary alert follows over-temp event, also in test mode
// - Power-down message latches output high
// - Interrupt output enabled by config bit1
// - Enabled interrupt asserts on trip violation
// - Slave responds at address 0101110
// - First write byte loads pointer
module mpc_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic aux_reset_n,
	input wire logic power_lost_n,
	input wire logic general_input_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic nand_test_select,
	input wire logic [7:0] fan_speed_code,
	output logic [7:0] fan_speed_out,
	output logic fan_speed_oe,
	input wire logic over_temp_event,
	input wire logic trip_violation,
	output logic over_temp_alert_primary_n_out,
	output logic over_temp_alert_primary_n_oe,
	output logic over_temp_alert_secondary_n_out,
	output logic over_temp_alert_secondary_n_oe,
	output logic fan_off_out,
	output logic fan_off_oe,
	output logic remote_reset_out,
	output logic remote_reset_oe,
	output logic remote_off_out,
	output logic int_out,
	output logic int_oe
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pin_s1_reg;
	logic [5:0] pin_s2_reg;
	logic [5:0] pin_s3_reg;
	logic [5:0] pin_reg;
	logic rst_any;
	logic gen_in_active;
	logic test_mode;
	logic nand_result;
	logic [7:0] cfg_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic remote_off_reg;
	logic [7:0] rrst_cnt_reg;
	logic [7:0] ptr;
	logic [7:0] wr_data;
	logic wr_stb;
	logic [7:0] rd_data;
	logic rrst_req;
	logic pdown_req;
	logic alert_reg;

	// NAND chain across the synchronised pin levels
	function automatic logic mpc_nand_chain(input logic [5:0] v);
		logic r;
		r = v[0];
		for (int i = 1; i < mpc_pkg::PIN_N; i++) begin
			r = ~(r & v[i]);
		end
		return r;
	endfunction : mpc_nand_chain

	// Three-stage sampling of every pin
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_s1_reg <= mpc_pkg::PIN_RST;
			pin_s2_reg <= mpc_pkg::PIN_RST;
			pin_s3_reg <= mpc_pkg::PIN_RST;
		end else begin
			pin_s1_reg <= {nand_test_select, general_input_pin, power_lost_n,
				aux_reset_n, sda_in, scl_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// Level accepted once second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_reg <= mpc_pkg::PIN_RST;
		end else begin
			for (int i = 0; i < mpc_pkg::PIN_N; i++) begin
				if (pin_s2_reg[i] == pin_s3_reg[i]) begin
					pin_reg[i] <= pin_s3_reg[i];
				end
			end
		end
	end

	assign rst_any = !rst_n || !pin_reg[mpc_pkg::P_AUX];
	assign test_mode = pin_reg[mpc_pkg::P_TST];
	assign gen_in_active = ~(pin_reg[mpc_pkg::P_GEN] ^ cfg_reg[mpc_pkg::CFG_GEN_POL]);
	assign nand_result = mpc_nand_chain(pin_reg);

	// ----------------------------------------------------------------
	// SMBus slave and register access
	// ----------------------------------------------------------------
	mpc_smb_slave u_slave (
		.sys_clk(sys_clk),
		.rst_any(rst_any),
		.scl(pin_reg[mpc_pkg::P_SCL]),
		.sda(pin_reg[mpc_pkg::P_SDA]),
		.rd_data(rd_data),
		.sda_oe(sda_oe),
		.ptr(ptr),
		.wr_data(wr_data),
		.wr_stb(wr_stb)
	);
	assign sda_out = 1'b0;

	// Read mux on the pointer
	always_comb begin
		if (ptr == mpc_pkg::OFS_CFG) begin
			rd_data = cfg_reg;
		end else if (ptr == mpc_pkg::OFS_STATUS) begin
			rd_data = status_reg;
		end else if (ptr == mpc_pkg::OFS_REMOTE) begin
			rd_data = {6'h00, remote_off_reg, |rrst_cnt_reg};
		end else begin
			rd_data = mpc_pkg::BYTE_ZERO;
		end
	end

	assign rrst_req = wr_stb && ptr == mpc_pkg::OFS_REMOTE && wr_data[mpc_pkg::RF_RESET];
	assign pdown_req = wr_stb && ptr == mpc_pkg::OFS_REMOTE && wr_data[mpc_pkg::RF_PDOWN];

	// Configuration register
	// enable resets disabled
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			cfg_reg <= mpc_pkg::CFG_RST;
		end else if (wr_stb && ptr == mpc_pkg::OFS_CFG) begin
			cfg_reg <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	// Write one to clear, new events win
	always_comb begin
		status_next = status_reg;
		if (wr_stb && ptr == mpc_pkg::OFS_STATUS) begin
			status_next = status_reg & ~wr_data;
		end
		if (gen_in_active) begin
			status_next[mpc_pkg::ST_GEN_IN] = 1'b1;
		end
		if (trip_violation) begin
			status_next[mpc_pkg::ST_TRIP] = 1'b1;
		end
		if (over_temp_event) begin
			status_next[mpc_pkg::ST_ALERT] = 1'b1;
		end
	end

	// Status storage
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			status_reg <= mpc_pkg::STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// ----------------------------------------------------------------
	// Remote functions
	// ----------------------------------------------------------------
	// fixed-length reset pulse
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			rrst_cnt_reg <= mpc_pkg::BYTE_ZERO;
		end else if (rrst_req) begin
			rrst_cnt_reg <= mpc_pkg::RRST_CYC;
		end else if (rrst_cnt_reg != mpc_pkg::BYTE_ZERO) begin
			rrst_cnt_reg <= rrst_cnt_reg - mpc_pkg::CNT8_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			remote_off_reg <= 1'b0;
		end else if (!pin_reg[mpc_pkg::P_PWR]) begin
			remote_off_reg <= 1'b0;
		end else if (pdown_req) begin
			remote_off_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// alert and fan speed, fan stop
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			alert_reg <= 1'b0;
			fan_speed_out <= mpc_pkg::FAN_STOP;
		end else begin
			alert_reg <= over_temp_event;
			if (!pin_reg[mpc_pkg::P_PWR]) begin
				fan_speed_out <= mpc_pkg::FAN_STOP;
			end else if (over_temp_event) begin
				fan_speed_out <= mpc_pkg::FAN_FULL;
			end else begin
				fan_speed_out <= fan_speed_code;
			end
		end
	end

	// Open-drain and output drivers
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			fan_off_oe <= 1'b0;
			remote_reset_oe <= 1'b0;
			over_temp_alert_primary_n_oe <= 1'b0;
			over_temp_alert_secondary_n_oe <= 1'b0;
			int_oe <= 1'b0;
			fan_speed_oe <= 1'b0;
		end else begin
			fan_off_oe <= cfg_reg[mpc_pkg::CFG_FAN_OFF];
			remote_reset_oe <= rrst_cnt_reg != mpc_pkg::BYTE_ZERO;
			over_temp_alert_primary_n_oe <= test_mode ? ~nand_result : over_temp_event;
			over_temp_alert_secondary_n_oe <= over_temp_event;
			int_oe <= cfg_reg[mpc_pkg::CFG_INT_EN] && (trip_violation || |status_next);
			// fan pin output only outside test
			fan_speed_oe <= !test_mode;
		end
	end

	// Open-drain data levels are always low; remote off follows its register
	assign fan_off_out = 1'b0;
	assign remote_reset_out = 1'b0;
	assign over_temp_alert_primary_n_out = 1'b0;
	assign over_temp_alert_secondary_n_out = 1'b0;
	assign int_out = 1'b0;
	assign remote_off_out = remote_off_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst_any);

	a_fan_off_req: assert property (
		cfg_reg[mpc_pkg::CFG_FAN_OFF] |=> fan_off_oe)
		else $error("fan off request not driven");
	a_gen_in_status: assert property (
		gen_in_active && !$past(rst_any) |=> status_reg[mpc_pkg::ST_GEN_IN])
		else $error("input event not stored");
	a_aux_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!pin_reg[mpc_pkg::P_AUX] |=> cfg_reg == mpc_pkg::CFG_RST && !remote_off_reg)
		else $error("aux reset did not clear logic");
	a_power_lost: assert property (
		!pin_reg[mpc_pkg::P_PWR] |=> !remote_off_reg && fan_speed_out == mpc_pkg::FAN_STOP)
		else $error("power loss not honoured");
	a_rrst_start: assert property (
		rrst_req |=> rrst_cnt_reg == mpc_pkg::RRST_CYC ##1 remote_reset_oe)
		else $error("remote reset pulse missing");
	a_rrst_length: assert property (
		$rose(remote_reset_oe) |-> $past(rrst_cnt_reg) == mpc_pkg::RRST_CYC)
		else $error("remote reset length wrong");
	a_test_route: assert property (
		test_mode |=> over_temp_alert_primary_n_oe == ~$past(nand_result))
		else $error("nand result not routed");
	a_fan_pin_dir: assert property (
		test_mode |=> !fan_speed_oe)
		else $error("fan pin driven in test mode");
	a_alert_full: assert property (
		over_temp_event && pin_reg[mpc_pkg::P_PWR] |=> fan_speed_out == mpc_pkg::FAN_FULL)
		else $error("fan not at full speed");
	a_alert_second: assert property (
		over_temp_event |=> over_temp_alert_secondary_n_oe && alert_reg)
		else $error("secondary alert missing");
	a_pdown_hold: assert property (
		remote_off_reg && pin_reg[mpc_pkg::P_PWR] |=> remote_off_reg)
		else $error("power-down dropped early");
	a_int_gate: assert property (
		!cfg_reg[mpc_pkg::CFG_INT_EN] |=> !int_oe)
		else $error("interrupt driven while disabled");
	a_int_trip: assert property (
		cfg_reg[mpc_pkg::CFG_INT_EN] && trip_violation |=> int_oe)
		else $error("trip did not interrupt");

	c_rrst_pulse: cover property ($fell(remote_reset_oe));
	c_pdown_set: cover property ($rose(remote_off_reg));
	c_test_mode: cover property (test_mode ##1 over_temp_alert_primary_n_oe);
	c_int_fire: cover property ($rose(int_oe));

endmodule : mpc_top

// ===== test/mpc_host_model.sv
`timescale 1ns/1ps
module mpc_host_model (
	input wire logic sys_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// Bus idles released high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : gap

	// Start or repeated start
	task automatic start_cond();
		sda_drv = 1'b1;
		gap(10);
		scl = 1'b1;
		gap(40);
		sda_drv = 1'b0;
		gap(40);
		scl = 1'b0;
		gap(5);
	endtask : start_cond

	task automatic stop_cond();
		sda_drv = 1'b0;
		gap(50);
		scl = 1'b1;
		gap(40);
		sda_drv = 1'b1;
		gap(50);
	endtask : stop_cond

	// One clock pulse; data held through the high time
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		gap(50);
		scl = 1'b1;
		gap(20);
		r = sda_line;
		gap(20);
		scl = 1'b0;
		gap(5);
	endtask : bit_io

	// Eight bits MSB first plus acknowledge slot
	task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
	endtask : byte_io

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
		input logic [7:0] val, output logic ack);
		logic [8:0] rx;
		start_cond();
		byte_io({dev, 1'b0, 1'b1}, rx);
		ack = ~rx[0];
		byte_io({ofs, 1'b1}, rx);
		byte_io({val, 1'b1}, rx);
		stop_cond();
	endtask : write_reg

	// Pointer write, repeated start, one byte then no acknowledge
	task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val);
		logic [8:0] rx;
		start_cond();
		byte_io({mpc_pkg::SMB_ADDR, 1'b0, 1'b1}, rx);
		byte_io({ofs, 1'b1}, rx);
		start_cond();
		byte_io({mpc_pkg::SMB_ADDR, 1'b1, 1'b1}, rx);
		byte_io({8'hFF, 1'b1}, rx);
		val = rx[8:1];
		stop_cond();
	endtask : read_reg
endmodule : mpc_host_model

// ===== test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) \
	n_checks++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("Error at %0t ns: got %0h expected %0h", $time, a, e); \
	end
module testbench;
	logic sys_clk, rst_n, aux_reset_n, power_lost_n, general_input_pin, nand_test_select;
	logic over_temp_event, trip_violation, fan_speed_oe, ot_p_oe, ot_s_oe, fan_off_oe;
	logic rr_oe, remote_off_out, int_oe, sda_oe, scl, sda_drv, ack;
	logic [7:0] fan_speed_code, fan_speed_out, rd_byte, code;
	logic [3:0] sel_q[$];
	logic [15:0] exp_q[$];
	logic [3:0] s;
	logic [15:0] e;
	int pulse_len, bad_count, n_checks;
	event note_ev;
	wire logic sda_line;
	wire logic [5:0] od_lvl;

	// Open-drain data line with pull-up
	assign sda_line = sda_drv & ~sda_oe;

	mpc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .aux_reset_n(aux_reset_n),
		.power_lost_n(power_lost_n), .general_input_pin(general_input_pin),
		.scl_in(scl), .sda_in(sda_line), .sda_out(od_lvl[0]), .sda_oe(sda_oe),
		.nand_test_select(nand_test_select), .fan_speed_code(fan_speed_code),
		.fan_speed_out(fan_speed_out), .fan_speed_oe(fan_speed_oe),
		.over_temp_event(over_temp_event), .trip_violation(trip_violation),
		.over_temp_alert_primary_n_out(od_lvl[1]),
		.over_temp_alert_primary_n_oe(ot_p_oe),
		.over_temp_alert_secondary_n_out(od_lvl[2]),
		.over_temp_alert_secondary_n_oe(ot_s_oe),
		.fan_off_out(od_lvl[3]), .fan_off_oe(fan_off_oe), .remote_reset_out(od_lvl[4]),
		.remote_reset_oe(rr_oe), .remote_off_out(remote_off_out), .int_out(od_lvl[5]),
		.int_oe(int_oe));

	mpc_host_model host_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
		.sda_drv(sda_drv));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	function automatic logic [15:0] observe(input logic [3:0] sel);
		case (sel)
			4'h0: observe = {8'h00, fan_speed_out};
			4'h1: observe = {15'h0000, fan_speed_oe};
			4'h2: observe = {15'h0000, ot_p_oe};
			4'h3: observe = {15'h0000, ot_s_oe};
			4'h4: observe = {15'h0000, fan_off_oe};
			4'h5: observe = {15'h0000, remote_off_out};
			4'h6: observe = {15'h0000, int_oe};
			4'h7: observe = {8'h00, rd_byte};
			4'h8: observe = {15'h0000, ack};
			4'hA: observe = {10'h000, od_lvl};
			default: observe = pulse_len[15:0];
		endcase
	endfunction : observe

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	task automatic note(input logic [3:0] sel, input logic [15:0] val);
		sel_q.push_back(sel);
		exp_q.push_back(val);
		->note_ev;
	endtask : note

	task automatic wreg(input logic [7:0] ofs, input logic [7:0] val);
		host_u.write_reg(mpc_pkg::SMB_ADDR, ofs, val, ack);
	endtask : wreg

	task automatic results();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// Oldest note against the outputs
	initial begin
		forever begin
			@(note_ev);
			while (sel_q.size() > 0) begin
				s = sel_q.pop_front();
				e = exp_q.pop_front();
				`CHK(observe(s), e)
			end
		end
	end

	// Length of the remote reset pulse
	task automatic measure_pulse();
		int t;
		t = 0;
		pulse_len = 0;
		while (rr_oe !== 1'b1 && t < 5000) begin
			cyc(1);
			t++;
		end
		while (rr_oe === 1'b1 && pulse_len < 300) begin
			cyc(1);
			pulse_len++;
		end
		if (t >= 5000) begin
			bad_count++;
			$display("Error at %0t ns: got %0h expected %0h", $time, rr_oe, 1'b1);
			results();
		end
	endtask : measure_pulse

	initial begin
		{rst_n, nand_test_select, over_temp_event, trip_violation, general_input_pin} = 5'h00;
		{aux_reset_n, power_lost_n} = 2'h3;
		fan_speed_code = 8'h00;
		pulse_len = 0;
		void'($urandom(32'h86f1));
		cyc(20);
		note(4'h0, 16'h0000); note(4'h2, 16'h0000); note(4'h4, 16'h0000);
		note(4'h5, 16'h0000); note(4'h6, 16'h0000); note(4'h1, 16'h0000);
		rst_n = 1'b1;
		cyc(10);
		for (int i = 0; i < 4; i++) begin
			code = 8'($urandom_range(0, 255));
			fan_speed_code = code;
			cyc(3);
			note(4'h0, {8'h00, code}); note(4'h1, 16'h0001);
		end
		over_temp_event = 1'b1;
		cyc(3);
		note(4'h0, 16'h00FF); note(4'h2, 16'h0001); note(4'h3, 16'h0001);
		over_temp_event = 1'b0;
		cyc(3);
		note(4'h0, {8'h00, code}); note(4'h2, 16'h0000); note(4'h3, 16'h0000);
		nand_test_select = 1'b1;
		cyc(8);
		note(4'h1, 16'h0000);
		// Chain over scl,sda,aux,pwr=1, input=0, test=1 gives 0, pin pulled low
		note(4'h2, 16'h0001);
		nand_test_select = 1'b0;
		cyc(8);
		note(4'h1, 16'h0001);
		note(4'h2, 16'h0000);
		host_u.write_reg(mpc_pkg::SMB_ADDR ^ 7'h01, mpc_pkg::OFS_CFG, 8'h08, ack);
		note(4'h8, 16'h0000); note(4'h4, 16'h0000);
		wreg(mpc_pkg::OFS_CFG, 8'h08);
		cyc(3);
		note(4'h8, 16'h0001); note(4'h4, 16'h0001);
		// Open-drain pins only ever pull low
		note(4'hA, 16'h0000);
		host_u.read_reg(mpc_pkg::OFS_CFG, rd_byte);
		note(4'h7, 16'h0008);
		trip_violation = 1'b1;
		wreg(mpc_pkg::OFS_CFG, 8'h02);
		cyc(3);
		note(4'h6, 16'h0001); note(4'h4, 16'h0000);
		wreg(mpc_pkg::OFS_CFG, 8'h00);
		cyc(3);
		note(4'h6, 16'h0000);
		trip_violation = 1'b0;
		for (int p = 0; p < 2; p++) begin
			wreg(mpc_pkg::OFS_CFG, p[0] ? 8'h04 : 8'h00);
			general_input_pin = ~p[0];
			cyc(6);
			wreg(mpc_pkg::OFS_STATUS, 8'hFF);
			host_u.read_reg(mpc_pkg::OFS_STATUS, rd_byte);
			note(4'h7, 16'h0000);
			general_input_pin = p[0];
			cyc(6);
			host_u.read_reg(mpc_pkg::OFS_STATUS, rd_byte);
			note(4'h7, 16'h0010);
		end
		fork
			wreg(mpc_pkg::OFS_REMOTE, 8'h01);
			measure_pulse();
		join
		note(4'h9, {8'h00, mpc_pkg::RRST_CYC});
		wreg(mpc_pkg::OFS_REMOTE, 8'h02);
		cyc(3);
		note(4'h5, 16'h0001);
		host_u.read_reg(mpc_pkg::OFS_REMOTE, rd_byte);
		note(4'h7, 16'h0002);
		code = 8'($urandom_range(1, 255));
		fan_speed_code = code;
		power_lost_n = 1'b0;
		cyc(8);
		note(4'h5, 16'h0000); note(4'h0, 16'h0000);
		power_lost_n = 1'b1;
		cyc(8);
		note(4'h5, 16'h0000); note(4'h0, {8'h00, code});
		wreg(mpc_pkg::OFS_CFG, 8'h08);
		cyc(3);
		note(4'h4, 16'h0001);
		aux_reset_n = 1'b0;
		cyc(10);
		aux_reset_n = 1'b1;
		cyc(10);
		note(4'h4, 16'h0000);
		host_u.read_reg(mpc_pkg::OFS_CFG, rd_byte);
		note(4'h7, 16'h0000);
		cyc(2);
		results();
	end
endmodule : testbench
